// ### core/tcc_timer.v
// 8-bit timer with compare output, normal and clear-on-match modes
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.vh"

// Register map, every register eight bits wide
//   ctrl     [1:0] waveform mode, [5:4] compare output mode
//            [7] force strobe, acted on in the write cycle and read back as zero
//   count    counter value; a write wins over clear and count and blocks a match in the next tick
//   compare  compare value, used at once since neither supported mode buffers it
//   flags    [0] overflow, [1] compare match, [2] compare output state (read only)
//            writing one to bit 0 or bit 1 clears that flag; a set in the same cycle wins
// Waveform modes 1 and 3 only count up and wrap here; their pulse shaping is not built.
// Read data, pin value and pin enable are registered, one cycle behind their source.
// The timer tick comes from the prescaler on this same clock and needs no synchroniser.
// Hazards for software:
//   a count write equal to the compare value loses that match and so one output edge
//   a compare write below the counter in clear-on-match mode costs a full wrap first
//   force acts only in normal and clear-on-match modes, with the mode bits written with it

module tcc_timer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Timer tick from the prescaler, one cycle, same clock domain
  input wire timerTick,
  // Register port
  input wire [`TCC_ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  // Interrupt service acknowledges, one cycle each
  input wire ovfAck,
  input wire cmpAck,
  // Flags towards the interrupt logic
  output reg overflowFlag,
  output reg compareMatchFlag,
  // Port pin logic
  input wire portLatch,
  input wire pinDirectionBit,
  output reg pinOut,
  output reg pinOe
);

  // Software-visible state and the hidden match block
  reg [1:0] waveformMode_r;
  reg [1:0] compareOutputMode_r;
  reg [WIDTH-1:0] counterValue_r;
  reg [WIDTH-1:0] compareValue_r;
  reg compareOutputState_r;
  reg blockMatch_r;

  // Next values
  reg [1:0] waveformMode_nxt;
  reg [1:0] compareOutputMode_nxt;
  reg [WIDTH-1:0] counterValue_nxt;
  reg [WIDTH-1:0] compareValue_nxt;
  reg compareOutputState_nxt;
  reg blockMatch_nxt;
  reg overflowFlag_nxt;
  reg compareMatchFlag_nxt;
  reg [7:0] regRdData_nxt;
  reg pinOut_nxt;
  reg pinOe_nxt;

  // Decoded accesses
  wire wrCtrl;
  wire wrCount;
  wire wrCompare;
  wire wrFlags;
  wire forceStrobe;
  wire [1:0] wrWave;
  wire [1:0] wrCom;

  // Counter events
  wire modeNormal;
  wire modeClear;
  wire wrNonPwm;
  wire nonPwm;
  wire atMax;
  wire matchEq;
  wire matchHit;
  wire ctcClear;
  wire overflowHit;
  wire [WIDTH-1:0] counterInc;

  // Register write decode
  assign wrCtrl = regWr && (regAddr == `TCC_OFF_CTRL);
  assign wrCount = regWr && (regAddr == `TCC_OFF_COUNT);
  assign wrCompare = regWr && (regAddr == `TCC_OFF_COMPARE);
  assign wrFlags = regWr && (regAddr == `TCC_OFF_FLAGS);
  assign wrWave = regWrData[`TCC_CTRL_WAVE_HI:`TCC_CTRL_WAVE_LO];
  assign wrCom = regWrData[`TCC_CTRL_COM_HI:`TCC_CTRL_COM_LO];

  // Waveform mode decode, of the live mode and of the mode being written
  assign modeNormal = (waveformMode_r == `TCC_WAVE_NORMAL);
  assign modeClear = (waveformMode_r == `TCC_WAVE_CLEAR);
  assign wrNonPwm = (wrWave == `TCC_WAVE_NORMAL) || (wrWave == `TCC_WAVE_CLEAR);

  // Force only counts in non-PWM modes, judged on the mode being written
  assign forceStrobe = wrCtrl && regWrData[`TCC_CTRL_FORCE] && wrNonPwm;

  // Mode class and comparator
  assign nonPwm = modeNormal || modeClear;
  assign atMax = (counterValue_r == `TCC_CNT_MAX);
  // Live equality; a compare value below the counter is only met again after the wrap
  assign matchEq = (counterValue_r == compareValue_r);
  // A counter write blocks the match of the next tick
  assign matchHit = timerTick && matchEq && !blockMatch_r;
  // Counting depends on waveform mode alone
  assign ctcClear = matchHit && modeClear;
  // Passing max to zero overflows in every mode, except by a clear-on-match clear or a counter write
  assign overflowHit = timerTick && atMax && !ctcClear && !wrCount;
  // Plain increment; the wrap from max to bottom falls out of the width
  assign counterInc = counterValue_r + {{(WIDTH-1){1'b0}}, 1'b1};

  // Compare output action on a match or a force
  function actionResult;
    input [1:0] com;
    input cur;
    begin
      case (com)
        `TCC_COM_TOGGLE: actionResult = ~cur;
        `TCC_COM_CLEAR: actionResult = 1'b0;
        `TCC_COM_SET: actionResult = 1'b1;
        default: actionResult = cur;
      endcase
    end
  endfunction

  // Waveform mode bits
  always @* begin
    waveformMode_nxt = waveformMode_r;
    if (wrCtrl) begin
      waveformMode_nxt = wrWave;
    end
  end

  // Compare output mode bits, first used by the match after the write
  always @* begin
    compareOutputMode_nxt = compareOutputMode_r;
    if (wrCtrl) begin
      compareOutputMode_nxt = wrCom;
    end
  end

  // Compare value, written straight with no double buffer
  always @* begin
    compareValue_nxt = compareValue_r;
    if (wrCompare) begin
      compareValue_nxt = regWrData[WIDTH-1:0];
    end
  end

  // Counter: processor write first, then clear, then count
  always @* begin
    counterValue_nxt = counterValue_r;
    if (wrCount) begin
      counterValue_nxt = regWrData[WIDTH-1:0];
    end else if (ctcClear) begin
      counterValue_nxt = `TCC_CNT_BOTTOM;
    end else if (timerTick) begin
      counterValue_nxt = counterInc;
    end
  end

  // Match block armed by a counter write, spent on the next tick
  always @* begin
    blockMatch_nxt = blockMatch_r;
    if (wrCount) begin
      blockMatch_nxt = 1'b1;
    end else if (timerTick) begin
      blockMatch_nxt = 1'b0;
    end
  end

  // Compare output state, held apart from the pin
  always @* begin
    compareOutputState_nxt = compareOutputState_r;
    if (forceStrobe) begin
      compareOutputState_nxt = actionResult(wrCom, compareOutputState_r);
    end else if (matchHit && nonPwm) begin
      compareOutputState_nxt = actionResult(compareOutputMode_r, compareOutputState_r);
    end
  end

  // Overflow flag: set wins over an acknowledge or a write of one
  always @* begin
    overflowFlag_nxt = overflowFlag;
    if (ovfAck || (wrFlags && regWrData[`TCC_FLAG_OVF])) begin
      overflowFlag_nxt = 1'b0;
    end
    if (overflowHit) begin
      overflowFlag_nxt = 1'b1;
    end
  end

  // Compare match flag: set wins, and a forced compare never reaches it
  always @* begin
    compareMatchFlag_nxt = compareMatchFlag;
    if (cmpAck || (wrFlags && regWrData[`TCC_FLAG_CMP])) begin
      compareMatchFlag_nxt = 1'b0;
    end
    if (matchHit) begin
      compareMatchFlag_nxt = 1'b1;
    end
  end

  // Read mux; force strobe reads as zero, unmapped bits read zero
  always @* begin
    regRdData_nxt = `TCC_RST_BYTE;
    if (regRd) begin
      case (regAddr)
        `TCC_OFF_CTRL: begin
          regRdData_nxt[`TCC_CTRL_WAVE_HI:`TCC_CTRL_WAVE_LO] = waveformMode_r;
          regRdData_nxt[`TCC_CTRL_COM_HI:`TCC_CTRL_COM_LO] = compareOutputMode_r;
        end
        `TCC_OFF_COUNT: regRdData_nxt[WIDTH-1:0] = counterValue_r;
        `TCC_OFF_COMPARE: regRdData_nxt[WIDTH-1:0] = compareValue_r;
        `TCC_OFF_FLAGS: begin
          regRdData_nxt[`TCC_FLAG_OVF] = overflowFlag;
          regRdData_nxt[`TCC_FLAG_CMP] = compareMatchFlag;
          regRdData_nxt[`TCC_FLAG_STATE] = compareOutputState_r;
        end
        default: regRdData_nxt = `TCC_RST_BYTE;
      endcase
    end
  end

  // Pin value picks its source by compare output mode alone; direction from the port
  always @* begin
    pinOut_nxt = portLatch;
    if (compareOutputMode_r != `TCC_COM_NONE) begin
      pinOut_nxt = compareOutputState_r;
    end
    pinOe_nxt = pinDirectionBit;
  end

  // Waveform mode register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      waveformMode_r <= `TCC_WAVE_NORMAL;
    end else begin
      waveformMode_r <= waveformMode_nxt;
    end
  end

  // Compare output mode register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      compareOutputMode_r <= `TCC_COM_NONE;
    end else begin
      compareOutputMode_r <= compareOutputMode_nxt;
    end
  end

  // Counter register
  // Write, clear and count are already merged in its next value
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      counterValue_r <= {WIDTH{1'b0}};
    end else begin
      counterValue_r <= counterValue_nxt;
    end
  end

  // Compare value register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      compareValue_r <= {WIDTH{1'b0}};
    end else begin
      compareValue_r <= compareValue_nxt;
    end
  end

  // Compare output state register, apart from the pin
  // It keeps its value across waveform mode changes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      compareOutputState_r <= 1'b0;
    end else begin
      compareOutputState_r <= compareOutputState_nxt;
    end
  end

  // Match block register
  // Armed by a counter write even while no tick comes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      blockMatch_r <= 1'b0;
    end else begin
      blockMatch_r <= blockMatch_nxt;
    end
  end

  // Overflow flag register
  // Only a set, an acknowledge or a write of one moves it
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflowFlag <= 1'b0;
    end else begin
      overflowFlag <= overflowFlag_nxt;
    end
  end

  // Compare match flag register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      compareMatchFlag <= 1'b0;
    end else begin
      compareMatchFlag <= compareMatchFlag_nxt;
    end
  end

  // Read data register, zero outside the read slot
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= `TCC_RST_BYTE;
    end else begin
      regRdData <= regRdData_nxt;
    end
  end

  // Pin value register
  // Stands one cycle behind the mode bits and the state it shows
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut <= 1'b0;
    end else begin
      pinOut <= pinOut_nxt;
    end
  end

  // Pin enable register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOe <= 1'b0;
    end else begin
      pinOe <= pinOe_nxt;
    end
  end

endmodule // tcc_timer
`default_nettype wire

// ### core/tcc_defs.vh
// Constants of the 8-bit timer compare-output block
//
// Operation
// - Nonzero compare output mode drives pin from compare output state, not port latch.
// - Pin direction stays with pin direction bit; state shows only when output.
// - Pin override depends only on compare output mode, not waveform mode.
// - Compare output state register is separate from the pin.
// - State can be set up before pin is output and holds its value.
// - Compare output mode zero leaves the state unchanged on a match.
// - New compare output mode acts first at the next match after the write.
// - In non-PWM modes a force strobe applies the action at once.
// - Only waveform mode selects counting; compare output mode never affects it.
// - In non-PWM modes compare output mode picks set, clear or toggle.
// - Waveform mode 0: counter only increments, wraps 0xff to 0x00.
// - Normal mode sets overflow flag in the tick the counter becomes zero.
// - Hardware only sets overflow flag; interrupt service clears it.
// - Normal mode accepts a counter write at any time.
// - Waveform mode 2 clears the counter when it equals the compare value.
// - Clear-on-match mode raises compare match flag each time top is reached.
// - Compare value writes are direct; a value below counter misses until wrap.
// - Mode 1 in clear-on-match toggles the state each match.
// - Toggle frequency is clock over 2 times prescale times one plus compare.
// - Clear-on-match mode sets overflow flag as counter passes max to zero; here not when compare is max and the match clear does the pass.
// - Match sets compare match flag at the timer tick; writing one clears.
// - A counter write blocks any match in the following timer tick.
// - Forced compare changes only the state; no flag, no counter change.
// - A counter write wins over hardware clear or count in that cycle.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// Register offsets
`define TCC_ADDR_W 2
`define TCC_OFF_CTRL 2'h0
`define TCC_OFF_COUNT 2'h1
`define TCC_OFF_COMPARE 2'h2
`define TCC_OFF_FLAGS 2'h3

// Control register fields
`define TCC_CTRL_WAVE_LO 0
`define TCC_CTRL_WAVE_HI 1
`define TCC_CTRL_COM_LO 4
`define TCC_CTRL_COM_HI 5
`define TCC_CTRL_FORCE 7

// Flag register fields
`define TCC_FLAG_OVF 0
`define TCC_FLAG_CMP 1
`define TCC_FLAG_STATE 2

// Waveform modes
`define TCC_WAVE_NORMAL 2'h0
`define TCC_WAVE_PHASE 2'h1
`define TCC_WAVE_CLEAR 2'h2
`define TCC_WAVE_FAST 2'h3

// Compare output actions
`define TCC_COM_NONE 2'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3

// Counter limits and reset values
`define TCC_CNT_MAX 8'hff
`define TCC_CNT_BOTTOM 8'h00
`define TCC_RST_BYTE 8'h00

`endif

// ### tb/tcc_pin_model.sv
// Port pin model: output latch, direction bit and pad level
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
  // Clock
  input wire logic sys_clk,
  // Software side of the port
  input wire logic latchIn,
  input wire logic dirIn,
  // Timer side
  input wire logic pinOut,
  input wire logic pinOe,
  output var logic portLatch,
  output var logic pinDirectionBit,
  output logic padLevel
);
  logic padLast_r = 1'b0;
  // Port registers follow software writes; the pad remembers its last driven level
  always @(posedge sys_clk) begin
    portLatch <= latchIn;
    pinDirectionBit <= dirIn;
    if (pinOe) padLast_r <= pinOut;
  end
  // Undriven pad shows the inverse of its last driven level, never a stale copy
  assign padLevel = pinOe ? pinOut : ~padLast_r;
endmodule // tcc_pin_model
`default_nettype wire

// ### tb/tcc_timer_chk.sv
// Checker for the timer compare-output block ports
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.vh"
module tcc_timer_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Timer and register port
  input wire logic timerTick,
  input wire logic [`TCC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Flags and acknowledges
  input wire logic ovfAck,
  input wire logic cmpAck,
  input wire logic overflowFlag,
  input wire logic compareMatchFlag,
  // Pin logic
  input wire logic portLatch,
  input wire logic pinDirectionBit,
  input wire logic pinOut,
  input wire logic pinOe
);
  logic [1:0] comMode;
  logic blockPend;
  wire cntWr = regWr && regAddr == `TCC_OFF_COUNT;
  wire flgWr = regWr && regAddr == `TCC_OFF_FLAGS;
  // Shadow of the output mode bits and of the pending match block
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comMode <= 2'h0;
      blockPend <= 1'b0;
    end else begin
      if (regWr && regAddr == `TCC_OFF_CTRL) comMode <= regWrData[5:4];
      blockPend <= cntWr | (blockPend & ~timerTick);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Counter loaded with its top value, one quiet cycle, then one tick
  sequence sWriteTop;
    cntWr && regWrData == `TCC_CNT_MAX ##1 !timerTick && !regWr ##1 timerTick && !regWr;
  endsequence
  chk_pin_enable: assert property ($past(rst_b, 2) |-> pinOe == $past(pinDirectionBit))
    else $error("pin enable does not follow direction");
  chk_pin_latch: assert property ($past(rst_b, 2) && $past(comMode) == 2'h0 |-> pinOut == $past(portLatch))
    else $error("pin does not follow port latch");
  chk_pin_state: assert property ($past(regRd && regAddr == `TCC_OFF_FLAGS) && $past(comMode) != 2'h0
    |-> regRdData[`TCC_FLAG_STATE] == pinOut)
    else $error("pin differs from output state");
  chk_read_idle: assert property ($past(rst_b) && !$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  chk_ovf_hold: assert property ($fell(overflowFlag) |-> $past(ovfAck || flgWr && regWrData[0]))
    else $error("overflow flag cleared by hardware");
  chk_cmp_hold: assert property ($fell(compareMatchFlag) |-> $past(cmpAck || flgWr && regWrData[1]))
    else $error("match flag cleared unasked");
  chk_cmp_tick: assert property ($rose(compareMatchFlag) |-> $past(timerTick && !blockPend))
    else $error("match flag set without unblocked tick");
  chk_ovf_wrap: assert property (sWriteTop |=> overflowFlag)
    else $error("no overflow after top value");
  chk_ovf_tick: assert property ($rose(overflowFlag) |-> $past(timerTick))
    else $error("overflow flag set without tick");
endmodule // tcc_timer_chk
bind tcc_timer tcc_timer_chk chk (.sys_clk, .rst_b, .timerTick, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .ovfAck, .cmpAck, .overflowFlag, .compareMatchFlag, .portLatch, .pinDirectionBit, .pinOut, .pinOe);
`default_nettype wire

// ### tb/test_tcc_timer.sv
// Self-checking bench of the timer compare-output block
`timescale 1ns/1ns
`default_nettype none
module test_tcc_timer;
  logic sys_clk = 1'b0, rst_b = 1'b0, timerTick = 1'b0, regWr = 1'b0, regRd = 1'b0, ovfAck = 1'b0, cmpAck = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWrData = 8'h00;
  logic latchIn = 1'b0, dirIn = 1'b0, rdD1 = 1'b0;
  logic [31:0] seed = 32'h28;
  wire [7:0] regRdData;
  wire overflowFlag, compareMatchFlag, portLatch, pinDirectionBit, pinOut, pinOe, padLevel;
  logic [7:0] expQ[$];
  logic [7:0] ctl[5] = '{8'hb0, 8'ha2, 8'h90, 8'h82, 8'ha1};
  logic [7:0] want[5] = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h04};
  int fails = 0, checkCount = 0, cycles = 0;
  tcc_timer dut (.sys_clk, .rst_b, .timerTick, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .ovfAck,
    .cmpAck, .overflowFlag, .compareMatchFlag, .portLatch, .pinDirectionBit, .pinOut, .pinOe);
  tcc_pin_model pin (.sys_clk, .latchIn, .dirIn, .pinOut, .pinOe, .portLatch, .pinDirectionBit, .padLevel);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One bus cycle, then an idle cycle so strobes never rise twice in a step
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic tk(input int n);
    timerTick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    timerTick <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic ack(input logic o);
    ovfAck <= o;
    cmpAck <= !o;
    @(posedge sys_clk);
    ovfAck <= 1'b0;
    cmpAck <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Read data is compared with the oldest note in the slot after a read
  always @(posedge sys_clk) begin
    if (rdD1) check(regRdData, expQ.pop_front());
    rdD1 <= regRd;
  end
  // Random port latch, hang guard
  always @(posedge sys_clk) begin
    seed <= xs(seed);
    latchIn <= seed[0];
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(2'h3, 8'h00);
    rd(2'h0, 8'h00);
    bus(1'b1, 2'h1, 8'hff);
    tk(1);
    rd(2'h3, 8'h01);
    check({7'h0, overflowFlag}, 8'h01);
    rd(2'h1, 8'h00);
    ack(1'b1);
    rd(2'h3, 8'h00);
    check({7'h0, overflowFlag}, 8'h00);
    // Toggle waveform in clear-on-match mode, then a blocked match and a wrap
    bus(1'b1, 2'h2, 8'h03);
    bus(1'b1, 2'h0, 8'h12);
    bus(1'b1, 2'h1, 8'h00);
    tk(3);
    rd(2'h3, 8'h00);
    tk(1);
    rd(2'h3, 8'h06);
    check({7'h0, compareMatchFlag}, 8'h01);
    rd(2'h1, 8'h00);
    tk(4);
    rd(2'h3, 8'h02);
    ack(1'b0);
    bus(1'b1, 2'h1, 8'h03);
    tk(1);
    rd(2'h3, 8'h00);
    check({7'h0, compareMatchFlag}, 8'h00);
    rd(2'h1, 8'h04);
    tk(252);
    rd(2'h3, 8'h01);
    bus(1'b1, 2'h3, 8'h01);
    rd(2'h3, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 2'h0, ctl[i]);
      rd(2'h3, want[i]);
    end
    rd(2'h1, 8'h00);
    bus(1'b1, 2'h0, 8'hb0);
    check({7'h0, pinOe}, 8'h00);
    dirIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({7'h0, padLevel}, 8'h01);
    check({7'h0, pinOut}, 8'h01);
    bus(1'b1, 2'h0, 8'h00);
    repeat (20) @(posedge sys_clk);
    finish_test();
  end
endmodule // test_tcc_timer
`default_nettype wire
